/* File: shared/sci_map.svh */
// register offsets, field resets and timing counts of the status and current input handler
// assumes a 50 MHz pclk and an 8-bit apb byte address
// Operation
// - status input action is none, reset totalizer 1/2/3, reset all, or override; none after reset
// - trigger polarity high or low is selectable; action fires only at that level; high default
// - action fires after the level held 5 to 200 ms, 50 ms default; source holds it
// - current fault reaction is alarm, hold last valid value, or substitute; alarm default
// - substitute reaction uses a programmed signed value, default zero, when the current is outside the alarm limits
// - ranges 4-20 mA in three alarm variants and 0-20 mA set span and alarm limits
`ifndef SCI_MAP_SVH
`define SCI_MAP_SVH

`define SCI_OFF_CTRL 8'h00
`define SCI_OFF_QUAL 8'h04
`define SCI_OFF_LO 8'h08
`define SCI_OFF_HI 8'h0C
`define SCI_OFF_SUBST 8'h10
`define SCI_OFF_STATUS 8'h14
`define SCI_OFF_VALUE 8'h18
`define SCI_OFF_ISTAT 8'h1C
`define SCI_OFF_IMASK 8'h20

`define SCI_CTRL_RST 8'h18
`define SCI_QUAL_RST 8'h32
`define SCI_QUAL_MIN 8'h05
`define SCI_QUAL_MAX 8'hC8
`define SCI_LO_RST 32'h0000_0000
`define SCI_HI_RST 32'h0000_2710
`define SCI_SUBST_RST 32'h0000_0000

`define SCI_IRQ_FIRED 0
`define SCI_IRQ_FAULT_SET 1
`define SCI_IRQ_FAULT_CLR 2
`define SCI_IRQ_W 3

`define SCI_MS_NS 1000000
`define SCI_CLK_NS 20

`define SCI_FULL_UA 16'h4E20
`define SCI_BASE4_UA 16'h0FA0
`define SCI_BASE0_UA 16'h0000
`define SCI_STD_LO_UA 16'h0ED8
`define SCI_STD_HI_UA 16'h5014
`define SCI_VAR_LO_UA 16'h0E10
`define SCI_VAR_HI_UA 16'h5208
`define SCI_US_LO_UA 16'h0EA6
`define SCI_US_HI_UA 16'h5848
`define SCI_ZERO_LO_UA 16'h0000
`define SCI_ZERO_HI_UA 16'h57E4

`endif

/* File: shared/sci_pkg.sv */
// types of the status and current input handler
// field layouts match the control register of sci_map.svh
package sci_pkg;

    typedef enum logic [2:0] {
        SCI_ACT_NONE = 3'h0,
        SCI_ACT_TOT1 = 3'h1,
        SCI_ACT_TOT2 = 3'h2,
        SCI_ACT_TOT3 = 3'h3,
        SCI_ACT_ALL = 3'h4,
        SCI_ACT_OVERRIDE = 3'h5
    } sci_action_t;

    typedef enum logic [1:0] {
        SCI_RNG_4_20 = 2'h0,
        SCI_RNG_4_20_ALARM_LIMIT_RANGE_VARIANT = 2'h1,
        SCI_RNG_4_20_US = 2'h2,
        SCI_RNG_0_20 = 2'h3
    } sci_range_t;

    typedef enum logic [1:0] {
        SCI_FAIL_ALARM = 2'h0,
        SCI_FAIL_HOLD = 2'h1,
        SCI_FAIL_SUBST = 2'h2
    } sci_fail_t;

    typedef struct packed {
        sci_fail_t fail;
        sci_range_t range;
        logic pol_high;
        sci_action_t action;
    } sci_ctrl_t;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] base;
    } sci_limits_t;

    typedef enum logic [2:0] {
        SCI_ST_IDLE = 3'b001,
        SCI_ST_COUNT = 3'b010,
        SCI_ST_FIRED = 3'b100
    } sci_state_t;

endpackage : sci_pkg

/* File: logic/sci_scale.sv */
// linear map of a loop current onto two signed endpoint values
// assumes base current below full scale
`timescale 1ns/1ps
`default_nettype none
`include "sci_map.svh"
module sci_scale (
    // current in microamps and range base
    input wire logic [15:0] cur_ua,
    input wire logic [15:0] base_ua,
    // endpoints
    input wire logic signed [31:0] lo_val,
    input wire logic signed [31:0] hi_val,
    // result
    output logic signed [31:0] value
);
    logic signed [63:0] num;
    logic signed [63:0] quo;
    logic signed [63:0] den;

    always_comb begin
        num = (64'(signed'({1'b0, cur_ua})) - 64'(signed'({1'b0, base_ua})))
            * (64'(hi_val) - 64'(lo_val));
        den = 64'(signed'({1'b0, `SCI_FULL_UA})) - 64'(signed'({1'b0, base_ua}));
        quo = num / den;
        value = lo_val + quo[31:0];
    end
endmodule : sci_scale
`default_nettype wire

/* File: logic/sci_top.sv */
// status input qualifier and current input handler with an apb register file
// assumes status_in is asynchronous, cur_sample comes from logic on pclk
`timescale 1ns/1ps
`default_nettype none
`include "sci_map.svh"
module sci_top #(
    parameter int MS_CYCLES = `SCI_MS_NS / `SCI_CLK_NS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status input pin
    input wire logic status_in,
    // current samples
    input wire logic [15:0] cur_sample,
    input wire logic cur_sample_valid,
    // actions
    output logic [2:0] tot_reset,
    output logic flow_override,
    // process value
    output logic [31:0] pv_value,
    output logic pv_valid,
    output logic cur_alarm,
    // interrupt
    output logic irq
);
    function automatic logic [7:0] qual_clamp(input logic [7:0] q);
        if (q < `SCI_QUAL_MIN) begin
            return `SCI_QUAL_MIN;
        end else if (q > `SCI_QUAL_MAX) begin
            return `SCI_QUAL_MAX;
        end
        return q;
    endfunction : qual_clamp

    function automatic sci_pkg::sci_limits_t range_limits(input sci_pkg::sci_range_t r);
        sci_pkg::sci_limits_t l;
        l = '{lo: `SCI_STD_LO_UA, hi: `SCI_STD_HI_UA, base: `SCI_BASE4_UA};
        case (r)
            sci_pkg::SCI_RNG_4_20_ALARM_LIMIT_RANGE_VARIANT: begin
                l = '{lo: `SCI_VAR_LO_UA, hi: `SCI_VAR_HI_UA, base: `SCI_BASE4_UA};
            end
            sci_pkg::SCI_RNG_4_20_US: begin
                l = '{lo: `SCI_US_LO_UA, hi: `SCI_US_HI_UA, base: `SCI_BASE4_UA};
            end
            sci_pkg::SCI_RNG_0_20: begin
                l = '{lo: `SCI_ZERO_LO_UA, hi: `SCI_ZERO_HI_UA, base: `SCI_BASE0_UA};
            end
            default: begin
                l = '{lo: `SCI_STD_LO_UA, hi: `SCI_STD_HI_UA, base: `SCI_BASE4_UA};
            end
        endcase
        return l;
    endfunction : range_limits

    // register file state
    sci_pkg::sci_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] qual_reg, qual_next;
    logic [31:0] lo_reg, lo_next, hi_reg, hi_next, subst_reg, subst_next;
    logic [2:0] istat_reg, istat_next, imask_reg, imask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
    // status path state
    logic sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
    sci_pkg::sci_state_t state_reg, state_next;
    logic [15:0] pre_reg, pre_next;
    logic [7:0] ms_reg, ms_next;
    logic [2:0] tot_reg, tot_next;
    logic ovr_reg, ovr_next, fire_evt;
    // current path state
    logic fault_reg, fault_next, valid_reg, valid_next, alarm_reg, alarm_next;
    logic [31:0] val_reg, val_next, last_reg, last_next;
    logic fault_set_evt, fault_clr_evt;
    // shared terms
    logic active, wr_en, rd_cyc, cur_bad;
    logic [7:0] qual_eff;
    sci_pkg::sci_limits_t lim;
    logic signed [31:0] scaled;

    assign active = (lvl_reg == ctrl_reg.pol_high);
    assign qual_eff = qual_clamp(qual_reg);
    assign lim = range_limits(ctrl_reg.range);
    assign wr_en = psel & penable & pready_reg & pwrite;
    assign rd_cyc = psel & ~penable;
    assign cur_bad = (cur_sample < lim.lo) | (cur_sample > lim.hi);

    sci_scale u_scale (
        .cur_ua(cur_sample),
        .base_ua(lim.base),
        .lo_val(lo_reg),
        .hi_val(hi_reg),
        .value(scaled)
    );

    // apb register file
    always_comb begin
        ctrl_next = ctrl_reg;
        qual_next = qual_reg;
        lo_next = lo_reg;
        hi_next = hi_reg;
        subst_next = subst_reg;
        imask_next = imask_reg;
        istat_next = istat_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = rd_cyc;
        if (wr_en) begin
            case (paddr)
                `SCI_OFF_CTRL: ctrl_next = sci_pkg::sci_ctrl_t'(pwdata[7:0]);
                `SCI_OFF_QUAL: qual_next = pwdata[7:0];
                `SCI_OFF_LO: lo_next = pwdata;
                `SCI_OFF_HI: hi_next = pwdata;
                `SCI_OFF_SUBST: subst_next = pwdata;
                `SCI_OFF_ISTAT: istat_next = istat_reg & ~pwdata[2:0];
                `SCI_OFF_IMASK: imask_next = pwdata[2:0];
                default: imask_next = imask_reg;
            endcase
        end
        istat_next[`SCI_IRQ_FIRED] = istat_next[`SCI_IRQ_FIRED] | fire_evt;
        istat_next[`SCI_IRQ_FAULT_SET] = istat_next[`SCI_IRQ_FAULT_SET] | fault_set_evt;
        istat_next[`SCI_IRQ_FAULT_CLR] = istat_next[`SCI_IRQ_FAULT_CLR] | fault_clr_evt;
        irq_next = |(istat_reg & imask_reg);
        if (rd_cyc) begin
            pslverr_next = 1'b0;
            prdata_next = 32'h0000_0000;
            case (paddr)
                `SCI_OFF_CTRL: prdata_next = {24'h00_0000, 8'(ctrl_reg)};
                `SCI_OFF_QUAL: prdata_next = {24'h00_0000, qual_reg};
                `SCI_OFF_LO: prdata_next = lo_reg;
                `SCI_OFF_HI: prdata_next = hi_reg;
                `SCI_OFF_SUBST: prdata_next = subst_reg;
                `SCI_OFF_STATUS: prdata_next = {27'h000_0000, state_reg == sci_pkg::SCI_ST_FIRED,
                                                lvl_reg, alarm_reg, valid_reg, fault_reg};
                `SCI_OFF_VALUE: prdata_next = val_reg;
                `SCI_OFF_ISTAT: prdata_next = {29'h0000_0000, istat_reg};
                `SCI_OFF_IMASK: prdata_next = {29'h0000_0000, imask_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= sci_pkg::sci_ctrl_t'(`SCI_CTRL_RST);
            qual_reg <= `SCI_QUAL_RST;
            lo_reg <= `SCI_LO_RST;
            hi_reg <= `SCI_HI_RST;
            subst_reg <= `SCI_SUBST_RST;
            istat_reg <= 3'h0;
            imask_reg <= 3'h0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            qual_reg <= qual_next;
            lo_reg <= lo_next;
            hi_reg <= hi_next;
            subst_reg <= subst_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // status input qualification
    always_comb begin
        lvl_next = (sync2_reg == sync3_reg) ? sync3_reg : lvl_reg;
        state_next = state_reg;
        pre_next = 16'h0000;
        ms_next = 8'h00;
        tot_next = 3'h0;
        ovr_next = 1'b0;
        fire_evt = 1'b0;
        case (state_reg)
            sci_pkg::SCI_ST_IDLE: begin
                if (active) begin
                    state_next = sci_pkg::SCI_ST_COUNT;
                end
            end
            sci_pkg::SCI_ST_COUNT: begin
                if (!active) begin
                    state_next = sci_pkg::SCI_ST_IDLE;
                end else if (ms_reg >= qual_eff) begin
                    state_next = sci_pkg::SCI_ST_FIRED;
                    fire_evt = 1'b1;
                    case (ctrl_reg.action)
                        sci_pkg::SCI_ACT_TOT1: tot_next = 3'h1;
                        sci_pkg::SCI_ACT_TOT2: tot_next = 3'h2;
                        sci_pkg::SCI_ACT_TOT3: tot_next = 3'h4;
                        sci_pkg::SCI_ACT_ALL: tot_next = 3'h7;
                        sci_pkg::SCI_ACT_OVERRIDE: ovr_next = 1'b1;
                        default: tot_next = 3'h0;
                    endcase
                end else if (pre_reg == 16'(MS_CYCLES - 1)) begin
                    ms_next = ms_reg + 8'h01;
                end else begin
                    pre_next = pre_reg + 16'h0001;
                    ms_next = ms_reg;
                end
            end
            sci_pkg::SCI_ST_FIRED: begin
                if (!active) begin
                    state_next = sci_pkg::SCI_ST_IDLE;
                end else begin
                    ovr_next = (ctrl_reg.action == sci_pkg::SCI_ACT_OVERRIDE);
                end
            end
            default: state_next = sci_pkg::SCI_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            lvl_reg <= 1'b0;
            state_reg <= sci_pkg::SCI_ST_IDLE;
            pre_reg <= 16'h0000;
            ms_reg <= 8'h00;
            tot_reg <= 3'h0;
            ovr_reg <= 1'b0;
        end else begin
            sync1_reg <= status_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg <= lvl_next;
            state_reg <= state_next;
            pre_reg <= pre_next;
            ms_reg <= ms_next;
            tot_reg <= tot_next;
            ovr_reg <= ovr_next;
        end
    end

    // current input fault handling
    always_comb begin
        fault_next = fault_reg;
        val_next = val_reg;
        valid_next = valid_reg;
        last_next = last_reg;
        alarm_next = alarm_reg;
        fault_set_evt = 1'b0;
        fault_clr_evt = 1'b0;
        if (cur_sample_valid) begin
            fault_next = cur_bad;
            fault_set_evt = cur_bad & ~fault_reg;
            fault_clr_evt = ~cur_bad & fault_reg;
            alarm_next = cur_bad & (ctrl_reg.fail == sci_pkg::SCI_FAIL_ALARM);
            if (!cur_bad) begin
                val_next = scaled;
                last_next = scaled;
                valid_next = 1'b1;
            end else begin
                case (ctrl_reg.fail)
                    sci_pkg::SCI_FAIL_HOLD: begin
                        val_next = last_reg;
                        valid_next = 1'b1;
                    end
                    sci_pkg::SCI_FAIL_SUBST: begin
                        val_next = subst_reg;
                        valid_next = 1'b1;
                    end
                    default: valid_next = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reg <= 1'b0;
            val_reg <= 32'h0000_0000;
            valid_reg <= 1'b0;
            last_reg <= 32'h0000_0000;
            alarm_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            val_reg <= val_next;
            valid_reg <= valid_next;
            last_reg <= last_next;
            alarm_reg <= alarm_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign tot_reset = tot_reg;
    assign flow_override = ovr_reg;
    assign pv_value = val_reg;
    assign pv_valid = valid_reg;
    assign cur_alarm = alarm_reg;
    assign irq = irq_reg;
endmodule : sci_top
`default_nettype wire

/* File: testbench/sci_asserts.sv */
// port relations of sci_top, held as concurrent assertions
// bound into every sci_top; MS_CYCLES follows the instance
`timescale 1ns/1ps
`default_nettype none
module sci_asserts #(
    parameter int MS_CYCLES = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // status and current
    input wire logic status_in,
    input wire logic cur_sample_valid,
    input wire logic [2:0] tot_reset,
    input wire logic flow_override,
    input wire logic [31:0] pv_value,
    input wire logic pv_valid,
    input wire logic cur_alarm
);
    logic last;
    int held;
    // cycles the pin has kept its level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            held <= 0;
        end else begin
            last <= status_in;
            held <= (status_in != last) ? 0 : held + 1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_tot_one_pulse: assert property (tot_reset != 3'h0 |=> tot_reset == 3'h0)
        else $error("totalizer reset not a pulse");
    a_tot_code_legal: assert property (tot_reset inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
        else $error("illegal totalizer reset code");
    a_action_exclusive: assert property (!(flow_override && tot_reset != 3'h0))
        else $error("two actions at once");
    a_fire_after_hold: assert property (tot_reset != 3'h0 |-> held >= 5 * MS_CYCLES)
        else $error("reset fired before qualification");
    a_override_after_hold: assert property ($rose(flow_override) |-> held >= 5 * MS_CYCLES)
        else $error("override before qualification");
    a_alarm_not_valid: assert property (cur_alarm |-> !pv_valid)
        else $error("alarm with valid value");
    a_value_on_sample: assert property ($changed(pv_value) |-> $past(cur_sample_valid))
        else $error("value changed without sample");
endmodule : sci_asserts
bind sci_top sci_asserts #(.MS_CYCLES(MS_CYCLES)) sci_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .status_in(status_in), .cur_sample_valid(cur_sample_valid),
    .tot_reset(tot_reset), .flow_override(flow_override), .pv_value(pv_value),
    .pv_valid(pv_valid), .cur_alarm(cur_alarm));
`default_nettype wire

/* File: testbench/sci_partner.sv */
// model of the switch contact and the loop current source
// one sample strobe every fourth pclk; a missing loop reads 0 uA
`timescale 1ns/1ps
`default_nettype none
module sci_partner (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // commands
    input wire logic level,
    input wire logic present,
    input wire logic [15:0] cur_ua,
    // pins
    output logic status_in,
    output logic [15:0] cur_sample,
    output logic cur_sample_valid
);
    logic [1:0] phase;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            status_in <= 1'b0;
            cur_sample <= 16'h0000;
            cur_sample_valid <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            status_in <= level;
            cur_sample_valid <= (phase == 2'h0);
            cur_sample <= (phase == 2'h0) ? (present ? cur_ua : 16'h0000) : ~cur_sample;
        end
    end
endmodule : sci_partner
`default_nettype wire

/* File: testbench/testbench.sv */
// apb sequences on sci_top against the switch and loop model
// MS_CYCLES is 10, so one ms is 10 pclk cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic lvl = 1'b0;
    logic pres = 1'b1;
    logic [15:0] cur = 16'h2EE0;
    logic [31:0] prdata, pv_value, rd;
    logic [15:0] cur_sample;
    logic [2:0] tot_reset;
    logic [2:0] seen_tot = 3'h0;
    logic pready, pslverr, status_in, cur_sample_valid, err;
    logic flow_override, pv_valid, cur_alarm, irq;
    logic seen_ovr = 1'b0;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    logic [31:0] rv [4] = '{32'h18, 32'h32, 32'h0, 32'h0};
    logic [2:0] tc [5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0};
    logic [3:0] flo = 4'b0101;
    logic [3:0] fhi = 4'b1011;
    always #10 pclk = ~pclk;
    sci_top #(.MS_CYCLES(10)) sci_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .status_in(status_in), .cur_sample(cur_sample), .cur_sample_valid(cur_sample_valid),
        .tot_reset(tot_reset), .flow_override(flow_override), .pv_value(pv_value),
        .pv_valid(pv_valid), .cur_alarm(cur_alarm), .irq(irq));
    sci_partner sci_partner_inst (
        .pclk(pclk), .presetn(presetn), .level(lvl), .present(pres), .cur_ua(cur),
        .status_in(status_in), .cur_sample(cur_sample), .cur_sample_valid(cur_sample_valid));
    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic hold(input logic v, input int n);
        seen_tot = 3'h0;
        seen_ovr = 1'b0;
        lvl <= v;
        for (int i = 0; i < n + 10; i++) begin
            @(posedge pclk);
            if (i == n - 1) begin
                lvl <= ~v;
            end
            if (tot_reset != 3'h0) begin
                seen_tot = tot_reset;
            end
            if (flow_override) begin
                seen_ovr = 1'b1;
            end
        end
    endtask : hold
    task automatic samp(input logic p, input logic [15:0] c);
        pres <= p;
        cur <= c;
        repeat (12) @(posedge pclk);
    endtask : samp
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ra[k], 32'h0);
            check(rd, rv[k]);
        end
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 8'h20, 32'h1);
        apb(1'b1, 8'h04, 32'h5);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, 8'h00, 32'(25 + k));
            hold(1'b1, 80);
            check({29'h0, seen_tot}, {29'h0, tc[k]});
            check({31'h0, seen_ovr}, {31'h0, k == 4});
            check({31'h0, irq}, 32'h1);
            apb(1'b1, 8'h1C, 32'h1);
            repeat (2) @(posedge pclk);
            check({31'h0, irq}, 32'h0);
        end
        apb(1'b1, 8'h00, 32'h19);
        hold(1'b1, 30);
        check({29'h0, seen_tot}, 32'h0);
        apb(1'b1, 8'h00, 32'h11);
        hold(1'b1, 80);
        check({29'h0, seen_tot}, 32'h0);
        hold(1'b0, 80);
        check({29'h0, seen_tot}, 32'h1);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b1, 8'h00, 32'h18);
        apb(1'b1, 8'h1C, 32'h7);
        hold(1'b1, 80);
        check({29'h0, seen_tot}, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check(rd & 32'h1, 32'h1);
        apb(1'b1, 8'h00, 32'h08);
        samp(1'b1, 16'h2EE0);
        check(pv_value, 32'h1388);
        check({31'h0, pv_valid}, 32'h1);
        apb(1'b1, 8'h00, 32'h38);
        samp(1'b1, 16'h3A98);
        check(pv_value, 32'h1D4C);
        apb(1'b1, 8'h08, 32'hFFFFFC18);
        samp(1'b1, 16'h3A98);
        check(pv_value, 32'h1C52);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 8'h00, 32'(8 + 16 * k));
            samp(1'b1, 16'h0E74);
            check({31'h0, cur_alarm}, {31'h0, flo[k]});
            samp(1'b1, 16'h5816);
            check({31'h0, cur_alarm}, {31'h0, fhi[k]});
        end
        check({31'h0, pv_valid}, 32'h0);
        apb(1'b1, 8'h00, 32'h48);
        samp(1'b1, 16'h2EE0);
        check(pv_value, 32'h1194);
        samp(1'b0, 16'h2EE0);
        check(pv_value, 32'h1194);
        check({31'h0, cur_alarm}, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFFFFF9);
        apb(1'b1, 8'h00, 32'h88);
        samp(1'b0, 16'h2EE0);
        check(pv_value, 32'hFFFFFFF9);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
